//--- core/pwm_interval_timer.sv
// Purpose: Dual reload PWM generator with interval interrupt timer
// Assumes: 125 MHz mclk; the slow clock is an approximate tick from mclk
// Notes: Reads return data one cycle after the read strobe
// Notes on behaviour
// R1: Counters and three reload registers reset to zero.
// R2: Inverted output always equals the inverse of the true output.
// R3: Slow clock by default; fast rates need select bit and clock gate.
// R4: Divide-by-ten option slows only the interval counter.
// R5: On run, PWM counter loads high reload, interval counter loads its reload.
// R6: At zero, PWM counter alternates high/low shadows; output follows phase.
// R7: Clocked-high mode toggles output at half timer clock during high phase.
// R8: Interval at zero waits for low-phase PWM zero, then interrupt and reload.
// R9: Reload writes reach shadows only when both counters zero in low phase.
// R10: Start-up state is all zero so an interrupt fires at start.
// R11: Disabled timer holds timer counters, shadows and phase in reset; control, reload, freeze and interrupt registers keep their values.
// R12: Reading reloads returns live counters.
// R13: Freeze set stops counting; freeze clear resumes.
// R14: Period is high reload plus one plus low reload plus one.
// R15: Interrupt interval is interval reload plus one ticks, rounded up to whole PWM periods.
// R16: Software: 16-bit timing uses interval reload, phase reloads zero.
// R17: Software: 17-bit timing uses 65535 high, remainder low, interval zero.
// R18: Software: fast divider zero when slow clock is chosen.
`include "pwm_timer_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pwm_interval_timer
   import pwm_timer_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata,
   output logic pwm_true_output,
   output logic pwm_inverted_output,
   output logic interval_interrupt,
   output logic irq
);
   state_t s_q;
   state_t s_d;
   logic fast_tick;
   logic tick;
   logic intv_tick;
   logic pwm_zero;
   logic both_zero_low;
   logic [2:0] fast_last;
   logic nxt_out;

   // Fast rate divider limit: 125, 62.5, 31.25, 15.625 MHz steps from the fast path
   function automatic logic [2:0] div_last(input logic [1:0] d);
      case (d)
         2'h0: div_last = 3'h0;
         2'h1: div_last = 3'h1;
         2'h2: div_last = 3'h3;
         default: div_last = 3'h7;
      endcase
   endfunction

   // Timer tick select; the fast path stays dead without its clock gate
   always_comb begin
      fast_last = div_last(s_q.clk.fast_clock_divider);
      fast_tick = (s_q.fast_cnt == fast_last) && s_q.clk.peripheral_timer_clock_gate;
      if (s_q.ctrl.clock_source_select) begin
         tick = fast_tick; // R3
      end else begin
         tick = (s_q.slow_cnt == `SLOW_CNT_LAST); // R3
      end
      intv_tick = tick && (!s_q.ctrl.interval_div_by_ten || s_q.div10_cnt == `DIV10_LAST); // R4
      pwm_zero = (s_q.pwm_phase_counter == `ZERO16);
      both_zero_low = pwm_zero && s_q.low_phase && (s_q.interval_counter == `ZERO16);
   end

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.interval_interrupt = 1'b0;
      s_d.rdata = `ZERO16;
      s_d.fast_cnt = (s_q.fast_cnt >= fast_last) ? 3'h0 : s_q.fast_cnt + 3'h1;
      s_d.slow_cnt = (s_q.slow_cnt == `SLOW_CNT_LAST) ? 12'h000 : s_q.slow_cnt + 12'h001;
      // Register writes
      if (wr_stb) begin
         if (addr == `OFF_CTRL) begin
            s_d.ctrl.timer_run_bit = wdata[`CTRL_RUN];
            s_d.ctrl.clock_source_select = wdata[`CTRL_SRC];
            s_d.ctrl.interval_div_by_ten = wdata[`CTRL_DIV10];
            s_d.ctrl.clocked_high_mode = wdata[`CTRL_CLKHI];
         end else if (addr == `OFF_HIGH) begin
            s_d.high_phase_reload = wdata; // R9
         end else if (addr == `OFF_LOW) begin
            s_d.low_phase_reload = wdata; // R9
         end else if (addr == `OFF_INTV) begin
            s_d.interval_reload = wdata;
         end else if (addr == `OFF_FRZ_SET) begin
            if (wdata[0]) s_d.timer_freeze_bit = 1'b1; // R13
         end else if (addr == `OFF_FRZ_CLR) begin
            if (wdata[0]) s_d.timer_freeze_bit = 1'b0; // R13
         end else if (addr == `OFF_CLKCFG) begin
            s_d.clk.peripheral_timer_clock_gate = wdata[`CLK_GATE];
            s_d.clk.fast_clock_divider = wdata[`CLK_DIV_HI:`CLK_DIV_LO];
         end else if (addr == `OFF_IRQ_STAT) begin
            if (wdata[0]) s_d.irq_stat = 1'b0;
         end else if (addr == `OFF_IRQ_MASK) begin
            s_d.irq_mask = wdata[0];
         end
      end
      // Register reads; reload addresses show live counters
      if (rd_stb) begin
         if (addr == `OFF_CTRL) begin
            s_d.rdata = {12'h000, s_q.ctrl.clocked_high_mode, s_q.ctrl.interval_div_by_ten,
                         s_q.ctrl.clock_source_select, s_q.ctrl.timer_run_bit};
         end else if (addr == `OFF_HIGH || addr == `OFF_LOW) begin
            s_d.rdata = s_q.pwm_phase_counter; // R12
         end else if (addr == `OFF_INTV) begin
            s_d.rdata = s_q.interval_counter; // R12
         end else if (addr == `OFF_FRZ_SET) begin
            s_d.rdata = {15'h0000, s_q.timer_freeze_bit};
         end else if (addr == `OFF_CLKCFG) begin
            s_d.rdata = {13'h0000, s_q.clk.fast_clock_divider, s_q.clk.peripheral_timer_clock_gate};
         end else if (addr == `OFF_IRQ_STAT) begin
            s_d.rdata = {15'h0000, s_q.irq_stat};
         end else if (addr == `OFF_IRQ_MASK) begin
            s_d.rdata = {15'h0000, s_q.irq_mask};
         end
      end
      // Timer core; disabled clears timer counters, shadows and phase, while the registers keep their values
      if (!s_q.ctrl.timer_run_bit) begin
         s_d.pwm_phase_counter = `ZERO16; // R11
         s_d.interval_counter = `ZERO16; // R11
         s_d.high_shadow = `ZERO16;
         s_d.low_shadow = `ZERO16;
         s_d.low_phase = 1'b1; // R10
         s_d.started = 1'b0;
         s_d.clk_phase = 1'b0;
         s_d.div10_cnt = 4'h0;
      end else if (!s_q.started) begin
         // Zero counters in low phase: start-up behaves as a completed cycle
         s_d.started = 1'b1;
      end else if (tick && !s_q.timer_freeze_bit) begin // R13
         s_d.clk_phase = !s_q.clk_phase; // R7
         if (s_q.ctrl.interval_div_by_ten) begin
            s_d.div10_cnt = (s_q.div10_cnt == `DIV10_LAST) ? 4'h0 : s_q.div10_cnt + 4'h1; // R4
         end
         if (both_zero_low) begin
            s_d.interval_interrupt = 1'b1; // R8 R10
            s_d.interval_counter = s_q.interval_reload; // R15
            s_d.pwm_phase_counter = s_q.high_phase_reload; // R5
            s_d.high_shadow = s_q.high_phase_reload; // R9
            s_d.low_shadow = s_q.low_phase_reload; // R9
            s_d.low_phase = 1'b0;
         end else begin
            if (pwm_zero) begin
               s_d.low_phase = !s_q.low_phase; // R6
               s_d.pwm_phase_counter = s_q.low_phase ? s_q.high_shadow : s_q.low_shadow; // R6 R14
            end else begin
               s_d.pwm_phase_counter = s_q.pwm_phase_counter - 16'h0001; // R5
            end
            if (intv_tick && s_q.interval_counter != `ZERO16) begin
               s_d.interval_counter = s_q.interval_counter - 16'h0001; // R8
            end
         end
      end
      // Start-up interrupt and reloads come from the first run cycle, before any tick
      if (!s_q.started && s_q.ctrl.timer_run_bit) begin
         s_d.interval_interrupt = 1'b1; // R10
         s_d.interval_counter = s_q.interval_reload; // R5
         s_d.pwm_phase_counter = s_q.high_phase_reload; // R5
         s_d.high_shadow = s_q.high_phase_reload;
         s_d.low_shadow = s_q.low_phase_reload;
         s_d.low_phase = 1'b0;
      end
      // Sticky status: set wins over a clear in the same cycle
      if (s_d.interval_interrupt) s_d.irq_stat = 1'b1;
      // Outputs from the next phase
      nxt_out = !s_d.low_phase && s_d.started;
      if (s_q.ctrl.clocked_high_mode && nxt_out) begin
         nxt_out = s_d.clk_phase; // R7
      end
      s_d.pwm_true_output = nxt_out; // R6
      s_d.pwm_inverted_output = !nxt_out; // R2
   end

   // Single state register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q <= '0; // R1
         s_q.low_phase <= 1'b1;
         s_q.pwm_inverted_output <= 1'b1; // R2
         s_q.clk.fast_clock_divider <= `RSTVAL_DIV;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= s_d.irq_stat && s_d.irq_mask;
      end
   end
   assign rdata = s_q.rdata;
   assign pwm_true_output = s_q.pwm_true_output;
   assign pwm_inverted_output = s_q.pwm_inverted_output;
   assign interval_interrupt = s_q.interval_interrupt;
endmodule
`default_nettype wire

//--- core/pwm_timer_consts.svh
// Purpose: Offsets, field positions and reset values of the PWM interval timer
// Assumes: Included by its bare name
// Notes: Word offsets on the plain register port
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH
`define ADDR_W 4
`define OFF_CTRL 4'h0
`define OFF_HIGH 4'h1
`define OFF_LOW 4'h2
`define OFF_INTV 4'h3
`define OFF_FRZ_SET 4'h4
`define OFF_FRZ_CLR 4'h5
`define OFF_CLKCFG 4'h6
`define OFF_IRQ_STAT 4'h7
`define OFF_IRQ_MASK 4'h8
`define CTRL_RUN 0
`define CTRL_SRC 1
`define CTRL_DIV10 2
`define CTRL_CLKHI 3
`define CLK_GATE 0
`define CLK_DIV_LO 1
`define CLK_DIV_HI 2
`define ZERO16 16'h0000
`define DIV10_LAST 4'h9
`define SLOW_CNT_LAST 12'hee3
`define RSTVAL_DIV 2'h0
`endif

//--- core/pwm_timer_pkg.sv
// Purpose: Types of the PWM interval timer
// Assumes: Constants come from the header
// Notes: Types only
package pwm_timer_pkg;
   typedef struct packed {
      logic timer_run_bit;
      logic clock_source_select;
      logic interval_div_by_ten;
      logic clocked_high_mode;
   } ctrl_t;
   typedef struct packed {
      logic peripheral_timer_clock_gate;
      logic [1:0] fast_clock_divider;
   } clkcfg_t;
   typedef struct packed {
      ctrl_t ctrl;
      clkcfg_t clk;
      logic [15:0] high_phase_reload;
      logic [15:0] low_phase_reload;
      logic [15:0] interval_reload;
      logic timer_freeze_bit;
      logic irq_stat;
      logic irq_mask;
      logic [15:0] pwm_phase_counter;
      logic [15:0] interval_counter;
      logic [15:0] high_shadow;
      logic [15:0] low_shadow;
      logic low_phase;
      logic started;
      logic clk_phase;
      logic [2:0] fast_cnt;
      logic [11:0] slow_cnt;
      logic [3:0] div10_cnt;
      logic pwm_true_output;
      logic pwm_inverted_output;
      logic interval_interrupt;
      logic [15:0] rdata;
   } state_t;
endpackage

//--- sim/pwm_timer_chk.sv
// Purpose: Port assertions for the PWM interval timer
// Assumes: Run and freeze bits mirrored from bus writes
// Notes: Sees only the top module ports
`include "pwm_timer_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [15:0] rdata,
   input wire logic pwm_true_output,
   input wire logic pwm_inverted_output,
   input wire logic interval_interrupt,
   input wire logic irq
);
   logic run_q, frz_q;
   // Mirrors of control bits, so checks know the mode
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         run_q <= 1'b0;
         frz_q <= 1'b0;
      end else if (wr_stb) begin
         if (addr == `OFF_CTRL) run_q <= wdata[`CTRL_RUN];
         if (addr == `OFF_FRZ_SET && wdata[0]) frz_q <= 1'b1;
         if (addr == `OFF_FRZ_CLR && wdata[0]) frz_q <= 1'b0;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   inv_pair_a: assert property (pwm_inverted_output == !pwm_true_output)
      else $error("inverted output wrong");
   rst_idle_a: assert property ($past(sys_rst) |-> rdata == 16'h0 && !pwm_true_output && !irq)
      else $error("outputs busy after reset");
   rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 16'h0)
      else $error("read data outside slot");
   start_int_a: assert property (wr_stb && addr == `OFF_CTRL && wdata[0] && !run_q |-> ##[1:2] interval_interrupt)
      else $error("no interrupt at start");
   off_quiet_a: assert property (!run_q && !$past(run_q) && !$past(run_q, 2) |-> !pwm_true_output && !interval_interrupt)
      else $error("stopped timer active");
   int_pulse_a: assert property (interval_interrupt |=> !interval_interrupt)
      else $error("interrupt pulse too long");
   int_low_a: assert property (interval_interrupt |-> !$past(pwm_true_output))
      else $error("interrupt outside low phase");
   frz_hold_a: assert property (frz_q && $past(frz_q) && $past(frz_q, 2) |-> $stable(pwm_true_output) && !interval_interrupt)
      else $error("frozen timer moved");
endmodule
bind pwm_interval_timer pwm_timer_chk i_pwm_timer_chk (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pwm_true_output(pwm_true_output),
   .pwm_inverted_output(pwm_inverted_output), .interval_interrupt(interval_interrupt), .irq(irq));
`default_nettype wire

//--- sim/pwm_interval_timer_test.sv
// Purpose: Self-checking bench for the PWM interval timer
// Assumes: Fast tick is mclk over 1, 2, 4 or 8
// Notes: Interval reloads sit on a PWM period edge
`include "pwm_timer_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pwm_interval_timer_test;
   logic mclk, sys_rst, wr_stb, rd_stb, pwm_true_output, pwm_inverted_output, interval_interrupt, irq, pv;
   logic [`ADDR_W-1:0] addr;
   logic [15:0] wdata, rdata, v;
   logic [31:0] lfsr;
   int miscompares, checks_done, iv, hi, ri, m, k;
   pwm_interval_timer i_pwm_interval_timer (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pwm_true_output(pwm_true_output),
      .pwm_inverted_output(pwm_inverted_output), .interval_interrupt(interval_interrupt), .irq(irq));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %0d seen %0d", nm, e, s);
      end
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // One strobe cycle then an idle one, so strobes never re-assert in one step
   task automatic bus(input logic w, input logic [`ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge mclk);
      wr_stb <= w;
      rd_stb <= !w;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_int();
      int t;
      t = 0;
      do begin
         @(negedge mclk);
         t++;
      end while (interval_interrupt !== 1'b1 && t < 40000);
      if (t >= 40000) begin
         miscompares++;
         finish_test();
      end
   endtask
   // Model: interval ends on the first PWM period edge after the interval count
   task automatic run_case(input int mh, nl, on, dv, cb);
      int t, p, ivt;
      t = (cb & 2) ? (1 << dv) : `SLOW_CNT_LAST + 1;
      p = mh + nl + 2;
      ivt = p * (((on + 1) * ((cb & 4) ? 10 : 1) + p - 1) / p);
      k = ivt / p;
      bus(1, `OFF_IRQ_STAT, 16'h1);
      bus(1, `OFF_CLKCFG, 16'(dv * 2 + 1));
      bus(1, `OFF_HIGH, 16'(mh));
      bus(1, `OFF_LOW, 16'(nl));
      chk("irq idle", 32'h0, irq);
      bus(1, `OFF_INTV, 16'(on));
      bus(1, `OFF_CTRL, 16'(cb + 1));
      wait_int();
      wait_int();
      iv = 0;
      hi = 0;
      ri = 0;
      pv = pwm_true_output;
      // One full interval: any window of one period sees the same counts
      do begin
         hi += (pwm_true_output === 1'b1);
         @(negedge mclk);
         iv++;
         ri += (pwm_true_output === 1'b1 && pv !== 1'b1);
         pv = pwm_true_output;
      end while (interval_interrupt !== 1'b1 && iv < 40000);
      chk("interval", ivt * t, iv);
      chk("high time", k * (mh + 1) * t / ((cb & 8) ? 2 : 1), hi);
      chk("rises", k * ((cb & 8) ? (mh + 1) / 2 : 1), ri);
      @(negedge mclk);
      @(negedge mclk);
      chk("irq", 32'h1, irq);
      bus(1, `OFF_CTRL, 16'h0);
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Reset, reset values, timing cases, freeze and stop
   initial begin
      sys_rst = 1'b1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = '0;
      wdata = '0;
      lfsr = 32'h741a;
      miscompares = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 10; a++) begin
         bus(0, a[3:0], 16'h0);
         chk("reset read", 32'h0, v);
      end
      bus(1, `OFF_IRQ_MASK, 16'h1);
      run_case(2, 4, 15, 0, 2);
      run_case(0, 0, 7, 0, 2);
      for (int d = 1; d < 4; d++)
         run_case(1, 1, 3, d, 2);
      run_case(9, 9, 3, 0, 6);
      run_case(7, 7, 15, 0, 10);
      run_case(0, 0, 1, 0, 0);
      for (int i = 0; i < 3; i++) begin
         lfsr = nxt(lfsr);
         k = 1 + int'(lfsr[7:6]);
         run_case(lfsr[2:0], lfsr[5:3], (lfsr[2:0] + lfsr[5:3] + 2) * k - 1, lfsr[8], 2);
      end
      bus(1, `OFF_CTRL, 16'h3);
      wait_int();
      bus(1, `OFF_FRZ_SET, 16'h1);
      bus(0, `OFF_INTV, 16'h0);
      m = v;
      bus(0, `OFF_HIGH, 16'h0);
      k = v;
      bus(0, `OFF_LOW, 16'h0);
      chk("live pwm count", k, v);
      repeat (20) @(negedge mclk);
      bus(0, `OFF_INTV, 16'h0);
      chk("frozen count", m, v);
      bus(1, `OFF_IRQ_MASK, 16'h0);
      bus(0, `OFF_IRQ_STAT, 16'h0);
      chk("status", 32'h1, v);
      chk("masked irq", 32'h0, irq);
      bus(1, `OFF_IRQ_STAT, 16'h1);
      bus(0, `OFF_FRZ_SET, 16'h0);
      chk("freeze bit", 32'h1, v);
      bus(1, `OFF_FRZ_CLR, 16'h1);
      wait_int();
      bus(1, `OFF_CTRL, 16'h0);
      repeat (3) @(negedge mclk);
      bus(0, `OFF_INTV, 16'h0);
      chk("stopped count", 32'h0, v);
      chk("stopped pwm", 32'h0, pwm_true_output);
      // Long high phase for 17-bit timing; only the start of the count is looked at
      bus(1, `OFF_HIGH, 16'hffff);
      bus(1, `OFF_LOW, 16'h0003);
      bus(1, `OFF_INTV, 16'h0000);
      bus(1, `OFF_CTRL, 16'h3);
      wait_int();
      bus(0, `OFF_HIGH, 16'h0);
      chk("long high count", 32'h1, 32'(v > 16'hff00));
      bus(1, `OFF_CTRL, 16'h0);
      finish_test();
   end
endmodule
`default_nettype wire
